// file: rtl/rws_pkg.sv
/*
 * Constants for the reset and warm-up sequencer: register map,
 * field positions, reset values, CPU init values and timing.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
package rws_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STATUS = 5'h04;
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
    localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h10;
    localparam logic [4:0] ADDR_TRIM = 5'h14;
    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_VD_EN = 0;
    localparam int CTRL_PORT_REL = 1;
    localparam int CTRL_EXT_HF = 2;
    localparam int CTRL_EXT_LF = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // ****************************************
    // Status and interrupt fields
    // ****************************************
    localparam int ST_TRIM_FAULT = 0;
    localparam int ST_SERIAL = 1;
    localparam int ST_STATE = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TRIM = 1;
    localparam int IRQ_INT_RST = 2;
    localparam int IRQ_W = 3;
    // ****************************************
    // CPU init values
    // ****************************************
    localparam logic [15:0] PC_MCU = 16'hfffe;
    localparam logic [15:0] PC_SERIAL = 16'h1ffe;
    localparam logic [15:0] SP_INIT = 16'h00ff;
    // ****************************************
    // Timing and trim
    // ****************************************
    localparam int WARMUP_DEF = 2048;
    localparam int TRIM_W = 8;
    localparam logic [1:0] TRIM_ADDR_DATA = 2'h0;
    localparam logic [1:0] TRIM_ADDR_CHECK = 2'h1;
    localparam logic [1:0] TRIM_LAST = 2'h2;
    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {
        RWS_HOLD = 2'b00,
        RWS_WARM = 2'b01,
        RWS_RUN = 2'b11
    } rws_state_type;
endpackage

// file: rtl/rws_sequencer.sv
/*
 * Reset and warm-up sequencer: merges reset requests, holds CPU and
 * peripherals, times warm-up on sys_clk, loads trim data, and
 * gives the CPU its start state. Assumes sys_clk is the high
 * frequency clock, pin requests are asynchronous and internal
 * requests come from logic on sys_clk.
 */
// Contract
// [RL1] Power-on, pin and internal requests all feed warm-up logic and reset.
// [RL2] Any active request clears warm-up counter and holds CPU, peripherals.
// [RL3] After release, counter counts clock cycles and stops at period end.
// [RL4] During warm-up, read trim data from store and latch it.
// [RL5] After warm-up the CPU starts at the vector in 0xFFFE and 0xFFFF.
// [RL6] A request during warm-up clears the counter; full warm-up restarts.
// [RL7] Same reset for all sources except some registers and voltage detect.
// [RL8] PC 0xFFFE normal or 0x1FFE serial, SP 0x00FF, through warm-up.
// [RL9] Bank select, interrupt enables and latches cleared until after warm-up.
// [RL10] RAM, data registers and arithmetic flags are not initialised.
// [RL11] Internal oscillator on, external oscillators off through warm-up.
// [RL12] Prescaler and divider held cleared until normal operation.
// [RL13] Watchdog disabled in reset and warm-up, enabled right after.
// [RL14] Only pin or power-on reset disables voltage detection.
// [RL15] Ports high-impedance through warm-up until software releases them.
// [RL16] Power-on and pin reset ORed; later release decides.
// [RL17] Abnormal trim data sets a readable trim fault flag.
module rws_sequencer
    import rws_pkg::*;
#(
    parameter int WARMUP_CYCLES = WARMUP_DEF,
    parameter int INT_REQS = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic por_req,
    input wire logic ext_reset_n,
    input wire logic [INT_REQS-1:0] int_reset_req,
    input wire logic serial_mode,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic trim_rd,
    output logic [1:0] trim_addr,
    input wire logic [TRIM_W-1:0] trim_rd_data,
    output logic [TRIM_W-1:0] trim_value,
    output logic cpu_reset,
    output logic periph_reset,
    output logic vector_fetch,
    output logic [15:0] program_counter,
    output logic [15:0] stack_pointer,
    output logic cpu_ctrl_clear,
    output logic int_osc_en,
    output logic ext_hf_osc_en,
    output logic ext_lf_osc_en,
    output logic prescaler_clear,
    output logic watchdog_en,
    output logic vd_en,
    output logic port_hiz,
    output logic irq
);
    // ****************************************
    // Request synchronisers and merge
    // ****************************************
    logic [1:0] por_sync;
    logic [1:0] ext_sync_n;
    logic [1:0] serial_sync;
    logic pin_req;
    logic any_req;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            por_sync <= 2'h3;
            ext_sync_n <= 2'h0;
            serial_sync <= 2'h0;
        end else begin
            por_sync <= {por_sync[0], por_req};
            ext_sync_n <= {ext_sync_n[0], ext_reset_n};
            serial_sync <= {serial_sync[0], serial_mode};
        end
    end

    assign pin_req = por_sync[1] | ~ext_sync_n[1]; // RL16
    assign any_req = pin_req | (|int_reset_req); // RL1

    // ****************************************
    // Sequencer and warm-up counter
    // ****************************************
    rws_state_type state;
    logic [$clog2(WARMUP_CYCLES+1)-1:0] warm_cnt;
    logic warm_end;

    assign warm_end = (warm_cnt == WARMUP_CYCLES[$bits(warm_cnt)-1:0] - 1'b1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= RWS_HOLD;
        end else if (any_req) begin
            state <= RWS_HOLD; // RL2 RL6
        end else begin
            case (state)
                RWS_HOLD: state <= RWS_WARM;
                RWS_WARM: if (warm_end) state <= RWS_RUN; // RL3
                RWS_RUN: state <= RWS_RUN;
                default: state <= RWS_HOLD;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || any_req || state != RWS_WARM) begin
            warm_cnt <= '0; // RL2 RL6
        end else if (!warm_end) begin
            warm_cnt <= warm_cnt + 1'b1; // RL3
        end
    end

    // ****************************************
    // Trim load during warm-up
    // ****************************************
    logic [1:0] trim_step;
    logic trim_fault;

    assign trim_rd = (state == RWS_WARM) && (trim_step != TRIM_LAST);
    assign trim_addr = trim_step;

    always_ff @(posedge sys_clk) begin
        if (rst || state != RWS_WARM) begin
            trim_step <= TRIM_ADDR_DATA;
        end else if (trim_rd) begin
            trim_step <= trim_step + 1'b1; // RL4
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trim_value <= '0;
        end else if (trim_rd && trim_step == TRIM_ADDR_DATA) begin
            trim_value <= trim_rd_data; // RL4
        end
    end

    // Check word must be the complement of the data word
    always_ff @(posedge sys_clk) begin
        if (rst || pin_req) begin
            trim_fault <= 1'b0;
        end else if (trim_rd && trim_step == TRIM_ADDR_CHECK) begin
            trim_fault <= (trim_rd_data != ~trim_value); // RL17
        end
    end

    // ****************************************
    // Mode strap and CPU start state
    // ****************************************
    logic serial_lat;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serial_lat <= 1'b0;
        end else if (state == RWS_HOLD) begin
            serial_lat <= serial_sync[1];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            program_counter <= PC_MCU;
            stack_pointer <= SP_INIT;
        end else if (state != RWS_RUN) begin
            program_counter <= serial_lat ? PC_SERIAL : PC_MCU; // RL8
            stack_pointer <= SP_INIT; // RL8
        end
    end

    // Data registers and RAM see no clear from here
    assign cpu_reset = (state != RWS_RUN); // RL2 RL10
    assign periph_reset = (state == RWS_HOLD); // RL2 RL7
    assign cpu_ctrl_clear = (state != RWS_RUN); // RL9
    assign prescaler_clear = (state != RWS_RUN); // RL12
    assign watchdog_en = (state == RWS_RUN); // RL13

    // One pulse when the CPU may fetch its start vector
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vector_fetch <= 1'b0;
        end else begin
            vector_fetch <= (state == RWS_WARM) && warm_end && !any_req; // RL5
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    logic [3:0] ctrl;
    logic vd_reg;
    logic bus_ack;
    logic wr_hit;
    logic [4:0] bus_addr;

    assign wr_hit = avs_write && bus_ack && avs_byteenable[0];
    assign bus_addr = avs_address;

    always_ff @(posedge sys_clk) begin
        if (rst || state != RWS_RUN) begin
            ctrl <= CTRL_RESET; // RL7
        end else if (wr_hit && bus_addr == ADDR_CTRL) begin
            ctrl <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || pin_req) begin
            vd_reg <= 1'b0; // RL14
        end else if (wr_hit && bus_addr == ADDR_CTRL
                     && state == RWS_RUN) begin
            vd_reg <= avs_writedata[CTRL_VD_EN];
        end
    end

    assign vd_en = vd_reg; // RL14
    assign int_osc_en = 1'b1; // RL11
    assign ext_hf_osc_en = (state == RWS_RUN) && ctrl[CTRL_EXT_HF]; // RL11
    assign ext_lf_osc_en = (state == RWS_RUN) && ctrl[CTRL_EXT_LF]; // RL11
    assign port_hiz = (state != RWS_RUN) || !ctrl[CTRL_PORT_REL]; // RL15

    // ****************************************
    // Interrupt status, clear and enable
    // ****************************************
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clr;
    logic trim_fault_d;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trim_fault_d <= 1'b0;
        end else begin
            trim_fault_d <= trim_fault;
        end
    end

    assign irq_event[IRQ_DONE] = vector_fetch;
    assign irq_event[IRQ_TRIM] = trim_fault && !trim_fault_d;
    assign irq_event[IRQ_INT_RST] = (|int_reset_req) && state != RWS_HOLD;
    assign irq_clr = (wr_hit && bus_addr == ADDR_IRQ_CLEAR)
                     ? avs_writedata[IRQ_W-1:0] : '0;

    // Set beats clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_event;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_enable <= '0;
        end else if (wr_hit && bus_addr == ADDR_IRQ_ENABLE) begin
            irq_enable <= avs_writedata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ****************************************
    // Avalon-MM slave, one wait state
    // ****************************************
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0;
        case (bus_addr)
            ADDR_CTRL: next_rdata = {28'h0, ctrl[3:1], vd_reg};
            ADDR_STATUS: next_rdata = {28'h0, state, serial_lat,
                                       trim_fault}; // RL17
            ADDR_IRQ_STATUS: next_rdata = {29'h0, irq_status};
            ADDR_IRQ_ENABLE: next_rdata = {29'h0, irq_enable};
            ADDR_TRIM: next_rdata = {24'h0, trim_value};
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read || avs_write) && !bus_ack;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !bus_ack) begin
            avs_readdata <= next_rdata;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
endmodule // rws_sequencer

// file: bench/rws_trim_store.sv
/* Trim store model: combinational read of data and check word.
   Assumes trim_rd and trim_addr come from the sequencer. */
module rws_trim_store
    import rws_pkg::*;
#(
    parameter logic [TRIM_W-1:0] TRIM_DATA = 8'h5a
) (
    input wire logic sys_clk,
    input wire logic trim_rd,
    input wire logic [1:0] trim_addr,
    input wire logic corrupt,
    output logic [TRIM_W-1:0] trim_rd_data
);
    logic [TRIM_W-1:0] junk = 8'h00;
    always_ff @(posedge sys_clk) begin
        junk <= junk + 8'h3b;
    end
    always_comb begin
        if (!trim_rd) begin
            trim_rd_data = junk;
        end else if (trim_addr == TRIM_ADDR_DATA) begin
            trim_rd_data = TRIM_DATA;
        end else begin
            trim_rd_data = corrupt ? TRIM_DATA : ~TRIM_DATA;
        end
    end
endmodule // rws_trim_store

// file: bench/rws_checker.sv
/* Port checker for rws_sequencer.
   Bound into every rws_sequencer instance. */
module rws_checker
    import rws_pkg::*;
#(
    parameter int WARMUP_CYCLES = WARMUP_DEF,
    parameter int INT_REQS = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [INT_REQS-1:0] int_reset_req,
    input wire logic serial_mode,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic trim_rd,
    input wire logic [1:0] trim_addr,
    input wire logic [TRIM_W-1:0] trim_rd_data,
    input wire logic [TRIM_W-1:0] trim_value,
    input wire logic cpu_reset,
    input wire logic periph_reset,
    input wire logic vector_fetch,
    input wire logic [15:0] program_counter,
    input wire logic [15:0] stack_pointer,
    input wire logic cpu_ctrl_clear,
    input wire logic int_osc_en,
    input wire logic ext_hf_osc_en,
    input wire logic ext_lf_osc_en,
    input wire logic prescaler_clear,
    input wire logic watchdog_en,
    input wire logic vd_en,
    input wire logic port_hiz
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    int warm_cnt;
    always_ff @(posedge sys_clk) begin
        if (rst || periph_reset) begin
            warm_cnt <= 0;
        end else if (cpu_reset) begin
            warm_cnt <= warm_cnt + 1;
        end
    end
    a_pc_start: assert property ($past(periph_reset, 2) && cpu_reset
        |-> program_counter == ($past(serial_mode, 4) ? PC_SERIAL : PC_MCU))
        else $error("pc start");
    a_hold_state: assert property (cpu_reset |-> cpu_ctrl_clear
        && prescaler_clear && port_hiz && int_osc_en && !ext_hf_osc_en
        && !ext_lf_osc_en && !watchdog_en && stack_pointer == SP_INIT)
        else $error("hold state");
    a_run_state: assert property (!cpu_reset |-> watchdog_en
        && !cpu_ctrl_clear && !prescaler_clear && !periph_reset)
        else $error("run state");
    a_vec_pulse: assert property (vector_fetch == $fell(cpu_reset))
        else $error("vector pulse");
    a_warm_len: assert property ($fell(cpu_reset)
        |-> warm_cnt == WARMUP_CYCLES) else $error("warm length");
    a_int_req: assert property (|int_reset_req |=> periph_reset)
        else $error("int request");
    a_trim_load: assert property ($fell(periph_reset) |-> trim_rd
        && trim_addr == TRIM_ADDR_DATA ##1 trim_rd
        && trim_addr == TRIM_ADDR_CHECK ##1 !trim_rd
        && trim_value == $past(trim_rd_data, 2)) else $error("trim load");
    a_vd_keep: assert property (|int_reset_req && vd_en |=> vd_en)
        else $error("vd kept");
    a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("one wait");
endmodule // rws_checker
bind rws_sequencer rws_checker #(.WARMUP_CYCLES(WARMUP_CYCLES),
    .INT_REQS(INT_REQS)) rws_checker_i (.sys_clk, .rst, .int_reset_req,
    .serial_mode, .avs_read, .avs_write, .avs_waitrequest, .trim_rd,
    .trim_addr, .trim_rd_data, .trim_value, .cpu_reset, .periph_reset,
    .vector_fetch, .program_counter, .stack_pointer, .cpu_ctrl_clear,
    .int_osc_en, .ext_hf_osc_en, .ext_lf_osc_en, .prescaler_clear,
    .watchdog_en, .vd_en, .port_hiz);

// file: bench/tb_rws_sequencer.sv
/* Testbench for rws_sequencer with the trim store model.
   Stands alone; the checker is bound to the design. */
module tb_rws_sequencer
    import rws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WU = 16;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic por_req = 1'b0;
    logic ext_reset_n = 1'b1;
    logic [3:0] int_reset_req = 4'h0;
    logic serial_mode = 1'b0;
    logic corrupt = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rd_q;
    logic [15:0] program_counter;
    logic [1:0] trim_addr;
    logic [TRIM_W-1:0] trim_rd_data;
    logic avs_waitrequest, trim_rd, periph_reset, vector_fetch;
    logic ext_hf_osc_en, vd_en, port_hiz, irq;
    int bad_count = 0;
    int cmp_count = 0;
    logic [37:0] rows [10] = '{
        {1'b0, ADDR_IRQ_STATUS, 32'h1},
        {1'b0, ADDR_STATUS, 32'hc},
        {1'b0, ADDR_TRIM, 32'h5a},
        {1'b1, ADDR_CTRL, 32'hf},
        {1'b0, ADDR_CTRL, 32'hf},
        {1'b1, ADDR_STATUS, 32'h3},
        {1'b0, ADDR_STATUS, 32'hc},
        {1'b0, 5'h18, 32'h0},
        {1'b1, ADDR_IRQ_CLEAR, 32'h1},
        {1'b0, ADDR_IRQ_STATUS, 32'h0}};
    rws_sequencer #(.WARMUP_CYCLES(WU)) rws_sequencer_i (.sys_clk, .rst,
        .por_req, .ext_reset_n, .int_reset_req, .serial_mode, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .trim_rd, .trim_addr,
        .trim_rd_data, .trim_value(), .cpu_reset(), .periph_reset,
        .vector_fetch, .program_counter, .stack_pointer(),
        .cpu_ctrl_clear(), .int_osc_en(), .ext_hf_osc_en,
        .ext_lf_osc_en(), .prescaler_clear(), .watchdog_en(), .vd_en,
        .port_hiz, .irq);
    rws_trim_store rws_trim_store_i (.sys_clk, .trim_rd, .trim_addr,
        .corrupt, .trim_rd_data);
    always #25 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 20) chk(32'h0, 32'h1);
        rd_q = avs_readdata;
    endtask
    task automatic idle();
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (vector_fetch !== 1'b1 && n < 200);
        if (n == 200) chk(32'h0, 32'h1);
    endtask
    task automatic pulse(input int i);
        int_reset_req[i] <= 1'b1;
        @(posedge sys_clk);
        int_reset_req <= 4'h0;
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        wait_run();
        chk({16'h0, program_counter}, {16'h0, PC_MCU});
        chk({port_hiz, ext_hf_osc_en, vd_en, irq}, 32'h8);
        bus(1'b1, ADDR_IRQ_ENABLE, 32'h1);
        idle();
        chk({31'h0, irq}, 32'h1);
        $display("reset test done");
        foreach (rows[i]) begin
            bus(rows[i][37], rows[i][36:32], rows[i][31:0]);
            if (!rows[i][37]) chk(rd_q, rows[i][31:0]);
        end
        idle();
        chk({port_hiz, ext_hf_osc_en, vd_en, irq}, 32'h6);
        avs_byteenable <= 4'he;
        bus(1'b1, ADDR_CTRL, 32'h0);
        avs_byteenable <= 4'hf;
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(rd_q, 32'hf);
        idle();
        $display("register test done");
        pulse(2);
        repeat (6) @(posedge sys_clk);
        pulse(0);
        wait_run();
        @(posedge sys_clk);
        chk({port_hiz, ext_hf_osc_en, vd_en, irq}, 32'hb);
        bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk(rd_q, 32'h5);
        bus(1'b1, ADDR_IRQ_CLEAR, 32'h7);
        idle();
        $display("internal test done");
        corrupt <= 1'b1;
        pulse(1);
        wait_run();
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd_q, 32'hd);
        idle();
        corrupt <= 1'b0;
        pulse(1);
        wait_run();
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd_q, 32'hc);
        idle();
        $display("trim test done");
        serial_mode <= 1'b1;
        ext_reset_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ext_reset_n <= 1'b1;
        wait_run();
        chk({15'h0, vd_en, program_counter}, {16'h0, PC_SERIAL});
        serial_mode <= 1'b0;
        bus(1'b1, ADDR_CTRL, 32'h1);
        idle();
        $display("pin test done");
        por_req <= 1'b1;
        ext_reset_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ext_reset_n <= 1'b1;
        repeat (30) @(posedge sys_clk);
        chk({31'h0, periph_reset}, 32'h1);
        por_req <= 1'b0;
        wait_run();
        chk({15'h0, vd_en, program_counter}, {16'h0, PC_MCU});
        $display("power test done");
        give_verdict();
    end
endmodule // tb_rws_sequencer
